//--- hw/ebcsp_pkg.sv
// constants for the expansion bus, chip select and port pin block
package ebcsp_pkg;
  // internal register offsets (internal region is 16'h0000 to 16'h01FF)
  localparam logic [15:0] OFS_PA_DATA = 16'h0000;
  localparam logic [15:0] OFS_PB_DATA = 16'h0001;
  localparam logic [15:0] OFS_PC_DATA = 16'h0002;
  localparam logic [15:0] OFS_PD_DATA = 16'h0003;
  localparam logic [15:0] OFS_PA_DIR = 16'h0004;
  localparam logic [15:0] OFS_PB_DIR = 16'h0005;
  localparam logic [15:0] OFS_PC_DIR = 16'h0006;
  localparam logic [15:0] OFS_PD_DIR = 16'h0007;
  localparam logic [15:0] OFS_PE_DATA = 16'h0008;
  localparam logic [15:0] OFS_PE_DIR = 16'h0009;
  localparam logic [15:0] OFS_PD_MODE = 16'h000A;
  localparam logic [15:0] OFS_PE_MODE = 16'h000B;
  localparam logic [15:0] OFS_TIMER_CTRL = 16'h000C;
  localparam logic [15:0] OFS_INT_CTRL = 16'h000D;
  localparam logic [15:0] OFS_WAKE_EN = 16'h000E;
  localparam logic [15:0] OFS_IRQ_STATUS = 16'h000F;
  localparam logic [15:0] OFS_IRQ_MASK = 16'h0010;
  localparam logic [15:0] OFS_TIMER_A = 16'h0011;
  localparam logic [15:0] OFS_TIMER_B_LO = 16'h0012;
  localparam logic [15:0] OFS_TIMER_B_HI = 16'h0013;
  // address map
  localparam logic [15:0] INTERNAL_TOP = 16'h01FF;
  localparam logic [15:0] ROM_BASE = 16'h3000;
  // timer control fields
  localparam int TCTRL_EXT_ROM_GATING_ENABLE_BIT = 7;
  localparam int TCTRL_TA_EN_BIT = 0;
  localparam int TCTRL_TB_EN_BIT = 1;
  localparam logic [7:0] TCTRL_RESET = 8'h80;
  // interrupt control fields
  localparam int ICTRL_ENABLE_BIT = 0;
  localparam int ICTRL_EDGE_BIT = 1;
  localparam int ICTRL_HIGH_BIT = 2;
  localparam logic [7:0] ICTRL_RESET = 8'h00;
  // port d mode fields
  localparam int DMODE_PHASE_BIT = 0;
  localparam int DMODE_EXP_BIT = 1;
  localparam logic [7:0] DMODE_RESET = 8'h01;
  localparam logic [7:0] PD_DIR_RESET = 8'h01;
  // port e mode field
  localparam int EMODE_SERIAL_BIT = 0;
  // irq status bits
  localparam int IRQ_EXT_BIT = 0;
  localparam int IRQ_WAKE_BIT = 1;
  localparam int IRQ_TA_BIT = 2;
  localparam logic [7:0] IRQ_USED = 8'h07;
  // port d pin roles in expansion mode
  localparam int PD_WR_N_BIT = 3;
  localparam int PD_RD_N_BIT = 4;
  localparam int PD_UPPER_LSB = 5;
  // oscillator to bus clock divide ratio
  localparam int BUS_CLK_DIV = 2;
endpackage : ebcsp_pkg

//--- hw/ebcsp_top.sv
// expansion bus, rom chip select, port pins, timers and interrupts
// Operation
// - bus phase clock is the oscillator clock divided by two
// - low reset input forces all state to defined start values
// - ports one, two, three and five are all inputs after reset
// - every port pin has software direction and output level
// - fourth port after reset: inputs except bit 0 driving phase clock
// - fourth port may carry upper address lines 13 to 15 and controls
// - each third-port input can be a wake-up interrupt source
// - fifth port may carry the serial interface signals
// - rom mode one: rom select low only for addresses 3000h-FFFFh
// - rom mode one: rom select only during phase clock high
// - rom mode zero: rom select always low
// - rom mode zero: data bus input only, never driven
// - rom mode bit sits in timer control register at 000Ch
// - addresses 0000h-01FFh use internal map, external data ignored
// - address lines 0 to 12 always driven outputs
// - data lines bidirectional to internal bus unless input-only mode
// - external interrupt: edge or level, polarity, mask
// - low timer halt input stops both timers

module ebcsp_sync #(
  parameter int W = 1
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] stable_o
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  // a bit changes only once the last two stages agree
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {s1_reg, s2_reg, s3_reg, stable_o} <= '0;
    end else begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      stable_o <= (s2_reg & s3_reg) | (stable_o & (s2_reg | s3_reg));
    end
  end
endmodule : ebcsp_sync

module ebcsp_top
  import ebcsp_pkg::*;
#(
  parameter int TIMER_B_W = 14
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  output logic irq_o,
  output logic bus_phase_clock_o,
  output logic [12:0] low_address_lines_o,
  input wire logic [7:0] ext_data_in_i,
  output logic [7:0] ext_data_out_o,
  output logic [7:0] ext_data_oe_o,
  output logic ext_rom_select_n_o,
  input wire logic external_interrupt_in_i,
  input wire logic timer_halt_n_i,
  input wire logic [7:0] first_port_pins_in_i,
  output logic [7:0] first_port_pins_out_o,
  output logic [7:0] first_port_pins_oe_o,
  input wire logic [7:0] second_port_pins_in_i,
  output logic [7:0] second_port_pins_out_o,
  output logic [7:0] second_port_pins_oe_o,
  input wire logic [7:0] wakeup_port_pins_in_i,
  output logic [7:0] wakeup_port_pins_out_o,
  output logic [7:0] wakeup_port_pins_oe_o,
  input wire logic [7:0] expansion_port_pins_in_i,
  output logic [7:0] expansion_port_pins_out_o,
  output logic [7:0] expansion_port_pins_oe_o,
  input wire logic [3:0] serial_port_pins_in_i,
  output logic [3:0] serial_port_pins_out_o,
  output logic [3:0] serial_port_pins_oe_o,
  input wire logic [3:0] serial_out_i,
  input wire logic [3:0] serial_oe_i,
  output logic [3:0] serial_in_o
);
  if (TIMER_B_W < 9 || TIMER_B_W > 16) begin : g_bad_width
    $error("TIMER_B_W must lie between 9 and 16");
  end

  logic phase_reg;
  logic phase_next;
  logic [15:0] addr_reg;
  logic [15:0] addr_next;
  logic [7:0] tctrl_reg;
  logic [7:0] ictrl_reg;
  logic [7:0] wake_en_reg;
  logic [7:0] dmode_reg;
  logic [7:0] emode_reg;
  logic [7:0] irq_status_reg;
  logic [7:0] irq_mask_reg;
  logic [7:0] irq_set;
  logic [7:0] timer_a_reg;
  logic [TIMER_B_W-1:0] timer_b_reg;
  logic [7:0] pa_data_reg, pb_data_reg, pc_data_reg, pd_data_reg;
  logic [7:0] pa_dir_reg, pb_dir_reg, pc_dir_reg, pd_dir_reg;
  logic [3:0] pe_data_reg, pe_dir_reg;
  logic [7:0] pa_in, pb_in, pc_in, pd_in, data_in;
  logic [3:0] pe_in;
  logic [1:0] misc_in;
  logic external_interrupt_in_prev_reg;
  logic [7:0] pc_prev_reg;
  logic ext_rom_gating_enable;
  logic is_internal;
  logic timers_tick;
  logic external_interrupt_in_active;
  logic [15:0] timer_b_wide;

  assign ext_rom_gating_enable = tctrl_reg[TCTRL_EXT_ROM_GATING_ENABLE_BIT];
  assign is_internal = (reg_addr_i <= INTERNAL_TOP);

  ebcsp_sync #(.W(46)) u_sync (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .async_i({first_port_pins_in_i, second_port_pins_in_i, wakeup_port_pins_in_i,
      expansion_port_pins_in_i, serial_port_pins_in_i, ext_data_in_i, timer_halt_n_i,
      external_interrupt_in_i}),
    .stable_o({pa_in, pb_in, pc_in, pd_in, pe_in, data_in, misc_in}));

  assign phase_next = ~phase_reg;
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // the address holds between accesses so the pins do not toggle needlessly
  assign addr_next = (reg_we_i | reg_re_i) ? reg_addr_i : addr_reg;
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_reg <= 16'h0000;
    end else begin
      addr_reg <= addr_next;
    end
  end

  // control registers take defined values under reset
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tctrl_reg <= TCTRL_RESET;
      ictrl_reg <= ICTRL_RESET;
      wake_en_reg <= 8'h00;
      dmode_reg <= DMODE_RESET;
      emode_reg <= 8'h00;
      irq_mask_reg <= 8'h00;
    end else if (reg_we_i) begin
      // rom mode bit lives in timer control
      if (reg_addr_i == OFS_TIMER_CTRL) begin
        tctrl_reg <= reg_wdata_i;
      end else if (reg_addr_i == OFS_INT_CTRL) begin
        ictrl_reg <= reg_wdata_i;
      end else if (reg_addr_i == OFS_WAKE_EN) begin
        wake_en_reg <= reg_wdata_i;
      end else if (reg_addr_i == OFS_PD_MODE) begin
        dmode_reg <= reg_wdata_i;
      end else if (reg_addr_i == OFS_PE_MODE) begin
        emode_reg <= reg_wdata_i;
      end else if (reg_addr_i == OFS_IRQ_MASK) begin
        irq_mask_reg <= reg_wdata_i & IRQ_USED;
      end
    end
  end

  // direction resets: all inputs except fourth port bit 0
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {pa_data_reg, pb_data_reg, pc_data_reg, pd_data_reg, pe_data_reg} <= '0;
      {pa_dir_reg, pb_dir_reg, pc_dir_reg, pe_dir_reg} <= '0;
      pd_dir_reg <= PD_DIR_RESET;
    end else if (reg_we_i) begin
      if (reg_addr_i == OFS_PA_DATA) begin
        pa_data_reg <= reg_wdata_i;
      end else if (reg_addr_i == OFS_PB_DATA) begin
        pb_data_reg <= reg_wdata_i;
      end else if (reg_addr_i == OFS_PC_DATA) begin
        pc_data_reg <= reg_wdata_i;
      end else if (reg_addr_i == OFS_PD_DATA) begin
        pd_data_reg <= reg_wdata_i;
      end else if (reg_addr_i == OFS_PE_DATA) begin
        pe_data_reg <= reg_wdata_i[3:0];
      end else if (reg_addr_i == OFS_PA_DIR) begin
        pa_dir_reg <= reg_wdata_i;
      end else if (reg_addr_i == OFS_PB_DIR) begin
        pb_dir_reg <= reg_wdata_i;
      end else if (reg_addr_i == OFS_PC_DIR) begin
        pc_dir_reg <= reg_wdata_i;
      end else if (reg_addr_i == OFS_PD_DIR) begin
        pd_dir_reg <= reg_wdata_i;
      end else if (reg_addr_i == OFS_PE_DIR) begin
        pe_dir_reg <= reg_wdata_i[3:0];
      end
    end
  end

  // both timers halt while the halt input is low
  assign timers_tick = phase_reg & misc_in[1];
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      timer_a_reg <= 8'h00;
      timer_b_reg <= '0;
    end else if (timers_tick) begin
      if (tctrl_reg[TCTRL_TA_EN_BIT]) begin
        timer_a_reg <= timer_a_reg + 8'h01;
      end
      if (tctrl_reg[TCTRL_TB_EN_BIT]) begin
        timer_b_reg <= timer_b_reg + TIMER_B_W'(1);
      end
    end
  end

  assign external_interrupt_in_active = ictrl_reg[ICTRL_HIGH_BIT] ? misc_in[0] : ~misc_in[0];
  always_comb begin
    irq_set = 8'h00;
    if (ictrl_reg[ICTRL_ENABLE_BIT]) begin
      if (ictrl_reg[ICTRL_EDGE_BIT]) begin
        irq_set[IRQ_EXT_BIT] = external_interrupt_in_active & (external_interrupt_in_prev_reg ^ misc_in[0]);
      end else begin
        irq_set[IRQ_EXT_BIT] = external_interrupt_in_active;
      end
    end
    // falling edge on an enabled input pin of the third port
    irq_set[IRQ_WAKE_BIT] = |(wake_en_reg & ~pc_dir_reg & pc_prev_reg & ~pc_in);
    irq_set[IRQ_TA_BIT] = timers_tick & tctrl_reg[TCTRL_TA_EN_BIT] & (&timer_a_reg);
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      external_interrupt_in_prev_reg <= 1'b0;
      pc_prev_reg <= 8'h00;
    end else begin
      external_interrupt_in_prev_reg <= misc_in[0];
      pc_prev_reg <= pc_in;
    end
  end

  // a new event wins over a write-one clear in the same cycle
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_status_reg <= 8'h00;
    end else if (reg_we_i && reg_addr_i == OFS_IRQ_STATUS) begin
      irq_status_reg <= (irq_status_reg & ~reg_wdata_i) | irq_set;
    end else begin
      irq_status_reg <= irq_status_reg | irq_set;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // read data valid only in the cycle after the strobe
  assign timer_b_wide = 16'(timer_b_reg);
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (!reg_re_i) begin
      reg_rdata_o <= 8'h00;
    end else if (!is_internal) begin
      // external data reaches the internal bus
      reg_rdata_o <= data_in;
    end else if (reg_addr_i == OFS_PA_DATA) begin
      // internal region never looks at the data pins
      reg_rdata_o <= (pa_dir_reg & pa_data_reg) | (~pa_dir_reg & pa_in);
    end else if (reg_addr_i == OFS_PB_DATA) begin
      reg_rdata_o <= (pb_dir_reg & pb_data_reg) | (~pb_dir_reg & pb_in);
    end else if (reg_addr_i == OFS_PC_DATA) begin
      reg_rdata_o <= (pc_dir_reg & pc_data_reg) | (~pc_dir_reg & pc_in);
    end else if (reg_addr_i == OFS_PD_DATA) begin
      reg_rdata_o <= (pd_dir_reg & pd_data_reg) | (~pd_dir_reg & pd_in);
    end else if (reg_addr_i == OFS_PE_DATA) begin
      reg_rdata_o <= {4'h0, (pe_dir_reg & pe_data_reg) | (~pe_dir_reg & pe_in)};
    end else if (reg_addr_i == OFS_PA_DIR) begin
      reg_rdata_o <= pa_dir_reg;
    end else if (reg_addr_i == OFS_PB_DIR) begin
      reg_rdata_o <= pb_dir_reg;
    end else if (reg_addr_i == OFS_PC_DIR) begin
      reg_rdata_o <= pc_dir_reg;
    end else if (reg_addr_i == OFS_PD_DIR) begin
      reg_rdata_o <= pd_dir_reg;
    end else if (reg_addr_i == OFS_PE_DIR) begin
      reg_rdata_o <= {4'h0, pe_dir_reg};
    end else if (reg_addr_i == OFS_PD_MODE) begin
      reg_rdata_o <= dmode_reg;
    end else if (reg_addr_i == OFS_PE_MODE) begin
      reg_rdata_o <= emode_reg;
    end else if (reg_addr_i == OFS_TIMER_CTRL) begin
      reg_rdata_o <= tctrl_reg;
    end else if (reg_addr_i == OFS_INT_CTRL) begin
      reg_rdata_o <= ictrl_reg;
    end else if (reg_addr_i == OFS_WAKE_EN) begin
      reg_rdata_o <= wake_en_reg;
    end else if (reg_addr_i == OFS_IRQ_STATUS) begin
      reg_rdata_o <= irq_status_reg;
    end else if (reg_addr_i == OFS_IRQ_MASK) begin
      reg_rdata_o <= irq_mask_reg;
    end else if (reg_addr_i == OFS_TIMER_A) begin
      reg_rdata_o <= timer_a_reg;
    end else if (reg_addr_i == OFS_TIMER_B_LO) begin
      reg_rdata_o <= timer_b_wide[7:0];
    end else if (reg_addr_i == OFS_TIMER_B_HI) begin
      reg_rdata_o <= timer_b_wide[15:8];
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // external bus pins, registered from next-state values to stay aligned
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_phase_clock_o <= 1'b0;
      low_address_lines_o <= 13'h0000;
      ext_data_out_o <= 8'h00;
      ext_data_oe_o <= 8'h00;
      ext_rom_select_n_o <= 1'b0;
    end else begin
      bus_phase_clock_o <= phase_next;
      low_address_lines_o <= addr_next[12:0];
      ext_data_out_o <= reg_wdata_i;
      // drive only on external writes in rom mode one
      ext_data_oe_o <= {8{reg_we_i & ~is_internal & ext_rom_gating_enable}};
      if (!ext_rom_gating_enable) begin
        // permanently selected, quiet bus for a two-chip system
        ext_rom_select_n_o <= 1'b0;
      end else begin
        // range decode gated with phase high
        ext_rom_select_n_o <= ~((addr_next >= ROM_BASE) & phase_next);
      end
    end
  end

  // port pin drivers; pins follow software one cycle late
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {first_port_pins_out_o, first_port_pins_oe_o, second_port_pins_out_o} <= '0;
      {second_port_pins_oe_o, wakeup_port_pins_out_o, wakeup_port_pins_oe_o} <= '0;
      expansion_port_pins_out_o <= 8'h00;
      expansion_port_pins_oe_o <= PD_DIR_RESET;
      {serial_port_pins_out_o, serial_port_pins_oe_o, serial_in_o} <= '0;
    end else begin
      first_port_pins_out_o <= pa_data_reg;
      first_port_pins_oe_o <= pa_dir_reg;
      second_port_pins_out_o <= pb_data_reg;
      second_port_pins_oe_o <= pb_dir_reg;
      wakeup_port_pins_out_o <= pc_data_reg;
      wakeup_port_pins_oe_o <= pc_dir_reg;
      if (dmode_reg[DMODE_EXP_BIT]) begin
        // upper address and strobes replace gpio
        expansion_port_pins_out_o[7:PD_UPPER_LSB] <= addr_next[15:13];
        expansion_port_pins_out_o[PD_RD_N_BIT] <= ~(reg_re_i & ~is_internal);
        expansion_port_pins_out_o[PD_WR_N_BIT] <= ~(reg_we_i & ~is_internal);
        expansion_port_pins_out_o[2:1] <= pd_data_reg[2:1];
        expansion_port_pins_oe_o[7:PD_WR_N_BIT] <= 5'h1F;
        expansion_port_pins_oe_o[2:1] <= pd_dir_reg[2:1];
      end else begin
        expansion_port_pins_out_o[7:1] <= pd_data_reg[7:1];
        expansion_port_pins_oe_o[7:1] <= pd_dir_reg[7:1];
      end
      // bit 0 carries the phase clock
      if (dmode_reg[DMODE_PHASE_BIT]) begin
        expansion_port_pins_out_o[0] <= phase_next;
        expansion_port_pins_oe_o[0] <= 1'b1;
      end else begin
        expansion_port_pins_out_o[0] <= pd_data_reg[0];
        expansion_port_pins_oe_o[0] <= pd_dir_reg[0];
      end
      // serial interface takes over the fifth port
      if (emode_reg[EMODE_SERIAL_BIT]) begin
        serial_port_pins_out_o <= serial_out_i;
        serial_port_pins_oe_o <= serial_oe_i;
      end else begin
        serial_port_pins_out_o <= pe_data_reg;
        serial_port_pins_oe_o <= pe_dir_reg;
      end
      serial_in_o <= pe_in;
    end
  end
endmodule : ebcsp_top

//--- sim/ebcsp_monitor.sv
// assertion checker on the ports of the expansion bus block
module ebcsp_monitor
  import ebcsp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic bus_phase_clock_o,
  input wire logic [12:0] low_address_lines_o,
  input wire logic [7:0] ext_data_out_o,
  input wire logic [7:0] ext_data_oe_o,
  input wire logic ext_rom_select_n_o,
  input wire logic [7:0] first_port_pins_oe_o,
  input wire logic [7:0] second_port_pins_oe_o,
  input wire logic [7:0] wakeup_port_pins_oe_o,
  input wire logic [7:0] expansion_port_pins_oe_o,
  input wire logic [3:0] serial_port_pins_oe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic ext_rom_gating_enable_reg;
  logic [15:0] held_reg;
  logic [1:0] live_reg;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // the first edge after release still samples reset values, so it is skipped
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) live_reg <= 2'd0;
    else if (live_reg != 2'd3) live_reg <= live_reg + 2'd1;
  end
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) ext_rom_gating_enable_reg <= 1'b1;
    else if (reg_we_i && reg_addr_i == OFS_TIMER_CTRL) ext_rom_gating_enable_reg <= reg_wdata_i[TCTRL_EXT_ROM_GATING_ENABLE_BIT];
  end
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) held_reg <= 16'h0000;
    else if (reg_we_i || reg_re_i) held_reg <= reg_addr_i;
  end
  sequence settled_s;
    live_reg != 2'd0 && $stable(ext_rom_gating_enable_reg) && $stable(held_reg);
  endsequence
  sequence ext_write_s;
    reg_we_i && reg_addr_i > INTERNAL_TOP && ext_rom_gating_enable_reg;
  endsequence
  phase_toggle_a: assert property (
    live_reg != 2'd0 |-> bus_phase_clock_o != $past(bus_phase_clock_o))
    else $error("phase clock did not toggle");
  rom_gate_a: assert property (
    settled_s ##0 (ext_rom_gating_enable_reg && !bus_phase_clock_o) |-> ext_rom_select_n_o)
    else $error("rom select low in low phase");
  rom_window_a: assert property (
    settled_s ##0 (ext_rom_gating_enable_reg && bus_phase_clock_o) |-> ext_rom_select_n_o == (held_reg < ROM_BASE))
    else $error("rom select wrong for address");
  rom_mode0_a: assert property (
    settled_s ##0 !ext_rom_gating_enable_reg |-> !ext_rom_select_n_o)
    else $error("rom select high with mode bit clear");
  data_quiet_a: assert property (
    settled_s ##0 !ext_rom_gating_enable_reg |-> ext_data_oe_o == 8'h00)
    else $error("data bus driven with mode bit clear");
  data_drive_a: assert property (
    ext_write_s |=> ext_data_oe_o == 8'hFF && ext_data_out_o == $past(reg_wdata_i))
    else $error("external write not driven");
  int_quiet_a: assert property (
    !(reg_we_i && reg_addr_i > INTERNAL_TOP) |=> ext_data_oe_o == 8'h00)
    else $error("data bus driven without external write");
  addr_follow_a: assert property (
    (reg_we_i || reg_re_i) |=> {3'b000, low_address_lines_o} == ($past(reg_addr_i) & 16'h1FFF))
    else $error("low address lines wrong");
  addr_hold_a: assert property (
    live_reg != 2'd0 && !(reg_we_i || reg_re_i) |=> $stable(low_address_lines_o))
    else $error("low address lines moved");
  reset_pins_a: assert property (
    live_reg == 2'd1 |-> (first_port_pins_oe_o | second_port_pins_oe_o | wakeup_port_pins_oe_o)
      == 8'h00 && serial_port_pins_oe_o == 4'h0 && expansion_port_pins_oe_o == 8'h01)
    else $error("pin directions wrong after reset");
endmodule : ebcsp_monitor

bind ebcsp_top ebcsp_monitor mon (.core_clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_we_i,
  .reg_re_i, .bus_phase_clock_o, .low_address_lines_o, .ext_data_out_o, .ext_data_oe_o,
  .ext_rom_select_n_o, .first_port_pins_oe_o, .second_port_pins_oe_o, .wakeup_port_pins_oe_o,
  .expansion_port_pins_oe_o, .serial_port_pins_oe_o);

//--- sim/ebcsp_ext_mem.sv
// external memory model behind the address, data and rom select pins
module ebcsp_ext_mem (
  input wire logic clk_i,
  input wire logic [12:0] addr_i,
  input wire logic sel_n_i,
  input wire logic [7:0] wdata_i,
  input wire logic wen_i,
  output logic [7:0] rdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [8192];
  logic [7:0] last_reg = 8'h00;
  initial for (int i = 0; i < 8192; i++) mem[i] = i[7:0] ^ 8'hA5;
  // a deselected chip floats: show the inverse of the last value, never a held copy
  assign rdata_o = sel_n_i ? ~last_reg : mem[addr_i];
  always @(posedge clk_i) begin
    if (!sel_n_i) last_reg <= rdata_o;
    if (wen_i) mem[addr_i] <= wdata_i;
  end
endmodule : ebcsp_ext_mem

//--- sim/ebcsp_top_test.sv
// self-checking bench for the expansion bus block
module ebcsp_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  import ebcsp_pkg::*;
  typedef struct packed {logic [15:0] a; logic w; logic [7:0] d; logic [7:0] e;} ebcsp_row_t;
  logic clk, rst_n, we, re, ext_irq, halt_n, irq, phase, rom_sel_n;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, rv, v0, d_in, d_out, d_oe, pa_oe, pb_oe, pc_oe, pc_in, pd_out, pd_oe;
  logic [3:0] pe_out, pe_oe, pe_in, ser_out, ser_oe, ser_in;
  logic [12:0] low_addr;
  logic [7:0] pa_out;
  int fails, n_tests, cycles;
  ebcsp_row_t rows [11];

  ebcsp_top dut (.core_clk_i(clk), .nrst_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .irq_o(irq), .bus_phase_clock_o(phase),
    .low_address_lines_o(low_addr), .ext_data_in_i(d_in), .ext_data_out_o(d_out),
    .ext_data_oe_o(d_oe), .ext_rom_select_n_o(rom_sel_n), .external_interrupt_in_i(ext_irq),
    .timer_halt_n_i(halt_n), .first_port_pins_in_i(8'h3C), .first_port_pins_out_o(pa_out),
    .first_port_pins_oe_o(pa_oe), .second_port_pins_in_i(8'hC3), .second_port_pins_out_o(),
    .second_port_pins_oe_o(pb_oe), .wakeup_port_pins_in_i(pc_in), .wakeup_port_pins_out_o(),
    .wakeup_port_pins_oe_o(pc_oe), .expansion_port_pins_in_i(8'h00),
    .expansion_port_pins_out_o(pd_out), .expansion_port_pins_oe_o(pd_oe),
    .serial_port_pins_in_i({pe_in}), .serial_port_pins_out_o(pe_out),
    .serial_port_pins_oe_o(pe_oe), .serial_out_i(ser_out), .serial_oe_i(ser_oe),
    .serial_in_o(ser_in));
  ebcsp_ext_mem ext (.clk_i(clk), .addr_i(low_addr), .sel_n_i(rom_sel_n), .wdata_i(d_out),
    .wen_i(d_oe[0]), .rdata_o(d_in));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 rv = rdata;
  endtask : rd
  // external reads need the address on the pins long before the sampled read
  task automatic rd_ext(input logic [15:0] a);
    rd(a);
    cyc(6);
    rd(a);
  endtask : rd_ext
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end

  initial begin
    {we, re, ext_irq, addr, wdata, ser_out, ser_oe, pe_in, fails, n_tests, cycles} = '0;
    {halt_n, pc_in} = 9'h1FF;
    rst_n = 1'b0;
    rows = '{
      '{16'h000C, 1'b0, 8'h00, 8'h80},   // mode bit set
      '{16'h0007, 1'b0, 8'h00, 8'h01},   // pin 0 out
      '{16'h000A, 1'b0, 8'h00, 8'h01},   // phase on pin
      '{16'h0004, 1'b0, 8'h00, 8'h00},
      '{16'h0005, 1'b0, 8'h00, 8'h00},
      '{16'h0006, 1'b0, 8'h00, 8'h00},
      '{16'h0009, 1'b0, 8'h00, 8'h00},
      '{16'h0100, 1'b0, 8'h00, 8'h00},   // unmapped place
      '{16'h0005, 1'b1, 8'hA5, 8'hA5},
      '{16'h0009, 1'b1, 8'h05, 8'h05},
      '{16'h0001, 1'b0, 8'h00, 8'h42}};  // input bits show the pins
    cyc(6);
    rst_n <= 1'b1;
    cyc(2);
    check({pa_oe, pb_oe}, 16'h0000);
    check({pc_oe, pe_oe, 4'h0}, 16'h0000);
    check(pd_oe, 16'h0001);
    v0 = pd_out;
    cyc(1);
    check(pd_out[0], !v0[0]);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      check(rv, rows[i].e);
    end
    wr(OFS_PA_DIR, 8'hFF);
    wr(OFS_PC_DIR, 8'h0F);
    cyc(3);
    check({pa_oe, pc_oe}, 16'hFF0F);
    wr(OFS_PA_DATA, 8'h5A);
    cyc(2);
    check({pa_out, pb_oe}, 16'h5AA5);
    wr(OFS_WAKE_EN, 8'h80);
    wr(OFS_IRQ_MASK, 8'h02);
    pc_in <= 8'h7F;
    cyc(8);
    check(irq, 1'b1);
    rd(OFS_IRQ_STATUS);
    check(rv & IRQ_USED, 8'h02);
    wr(OFS_IRQ_MASK, 8'h00);
    cyc(3);
    check(irq, 1'b0);
    wr(OFS_IRQ_STATUS, 8'h02);
    rd(OFS_IRQ_STATUS);
    check(rv[IRQ_WAKE_BIT], 1'b0);
    wr(OFS_IRQ_MASK, 8'h01);
    wr(OFS_INT_CTRL, 8'h05);
    ext_irq <= 1'b1;
    cyc(8);
    wr(OFS_IRQ_STATUS, 8'h01);
    cyc(1);
    check(irq, 1'b1);
    ext_irq <= 1'b0;
    cyc(6);
    wr(OFS_IRQ_STATUS, 8'h01);
    wr(OFS_INT_CTRL, 8'h03);
    ext_irq <= 1'b1;
    cyc(8);
    check(irq, 1'b0);
    ext_irq <= 1'b0;
    cyc(8);
    check(irq, 1'b1);
    wr(OFS_IRQ_MASK, 8'h00);
    halt_n <= 1'b0;
    wr(OFS_TIMER_CTRL, 8'h83);
    cyc(4);
    rd(OFS_TIMER_A);
    v0 = rv;
    cyc(20);
    rd(OFS_TIMER_A);
    check(rv, v0);
    halt_n <= 1'b1;
    cyc(6);
    rd(OFS_TIMER_A);
    v0 = rv;
    cyc(20);
    rd(OFS_TIMER_A);
    check(rv != v0, 1'b1);
    wr(OFS_PE_MODE, 8'h01);
    {ser_out, ser_oe, pe_in} <= 12'hAF5;
    cyc(6);
    check({pe_out, pe_oe, ser_in}, 12'hAF5);
    wr(OFS_PD_MODE, 8'h03);
    rd(16'hE000);
    cyc(3);
    check({pd_out[7:5], pd_oe[7:5]}, 6'h3F);
    wr(16'h4000, 8'h55);
    rd(16'h2000);
    cyc(4);
    wr(OFS_TIMER_CTRL, 8'h00);
    wr(16'h4001, 8'hAA);
    cyc(0);
    check({d_oe, 7'h00, rom_sel_n}, 16'h0000);
    rd_ext(16'h4000);
    check(rv, 8'h55);
    rd_ext(16'h4001);
    check(rv, 8'hA4);
    rd(OFS_TIMER_CTRL);
    check(rv, 8'h00);
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    cyc(2);
    check(pd_oe, 16'h0001);
    rd(OFS_TIMER_CTRL);
    check(rv, TCTRL_RESET);
    final_report();
  end
endmodule : ebcsp_top_test
